// ### design/smrc_consts.svh
// register offsets, field positions, reset values and timing counts of the
// halt-release controller; definitions only, included by the top design file and the test bench
`ifndef SMRC_CONSTS_SVH
`define SMRC_CONSTS_SVH

// register word offsets on the plain register port
`define SMRC_ADDR_SYSCTL 3'h0
`define SMRC_ADDR_WUCTL 3'h1
`define SMRC_ADDR_WUCOUNT 3'h2
`define SMRC_ADDR_KEYCFG 3'h3
`define SMRC_ADDR_STATUS 3'h4

// system_control_one fields
`define SMRC_BIT_HALT 7
`define SMRC_BIT_RELMODE 6
// warmup_counter_control fields
`define SMRC_BIT_WARMUP_CLOCK_SELECT 0
// key-on wakeup configuration fields
`define SMRC_BIT_KEYEN 0
`define SMRC_BIT_KEYLVL 1

// reset values
`define SMRC_SYSCTL_RST 8'h00
`define SMRC_WUCTL_RST 8'h00
`define SMRC_WUCOUNT_RST 8'hff
`define SMRC_KEYCFG_RST 8'h00

// core clocks in one machine cycle, the blind window after halt entry
`define SMRC_MC_CLKS 4

`endif

// ### design/smrc_pkg.sv
// types shared by the halt-release controller files
// assumes smrc_consts.svh carries the numeric constants
package smrc_pkg;

   typedef enum logic [1:0] {
      SMRC_RUN,
      SMRC_HALT,
      SMRC_WARM
   } smrc_state_t;

   typedef enum logic {
      SMRC_REL_EDGE,
      SMRC_REL_LEVEL
   } smrc_relmode_t;

endpackage

// ### design/smrc_sync_edge.sv
// two-flop synchroniser with edge detection for one asynchronous pin
// assumes core_clk is the always-on clock that keeps running in halt
`timescale 1ns/100ps

module smrc_sync_edge
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pinIn,
   output logic level,
   output logic rise,
   output logic fall
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } smrc_sync_t;

   smrc_sync_t core_reg;
   smrc_sync_t core_next;

   always_comb
   begin
      core_next = core_reg;
      core_next.meta = pinIn;
      core_next.sync = core_reg.meta;
      core_next.prev = core_reg.sync;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         core_reg <= '0;
      else
         core_reg <= core_next;
   end

   assign level = core_reg.sync;
   assign rise = core_reg.sync & ~core_reg.prev;
   assign fall = ~core_reg.sync & core_reg.prev;

endmodule // smrc_sync_edge

// ### design/smrc_warmup.sv
// warm-up counter: counts source clock ticks up to a programmed limit
// assumes tick is a one-cycle pulse per source period, same clock domain
`timescale 1ns/100ps

module smrc_warmup
#(
   parameter int WIDTH = 8
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   output logic busy,
   output logic done
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [WIDTH-1:0] cnt;
   } smrc_wu_t;

   smrc_wu_t core_reg;
   smrc_wu_t core_next;

   always_comb
   begin
      core_next = core_reg;
      core_next.done = 1'b0;
      if (start)
      begin
         core_next.busy = 1'b1;
         core_next.cnt = '0;
      end
      else if (core_reg.busy && tick)
      begin
         if (core_reg.cnt >= limit)
         begin
            core_next.busy = 1'b0;
            core_next.done = 1'b1;
         end
         else
            core_next.cnt = core_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         core_reg <= '0;
      else
         core_reg <= core_next;
   end

   assign busy = core_reg.busy;
   assign done = core_reg.done;

endmodule // smrc_warmup

// ### design/smrc_top.sv
// halt (stop mode) release controller: entry, wake sources, blind window,
// warm-up and resume
// assumes core_clk is an always-on clock that runs while the system clock
// is stopped; oscillator ticks and the main-clock select come from the
// clock generator on core_clk; wake pins are asynchronous
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "smrc_consts.svh"

module smrc_top
#(
   parameter int MC_CLKS = `SMRC_MC_CLKS,
   parameter int WU_WIDTH = 8
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic releasePin,
   input wire logic keyPin,
   input wire logic voltDetect,
   input wire logic resetWake,
   input wire logic mainOscLow,
   input wire logic highOscTick,
   input wire logic lowOscTick,
   output logic cpuRun,
   output logic oscStop,
   output logic tgClear,
   output logic warmupSrcLow,
   output logic highSpeedRunMode,
   output logic haltActive,
   output logic portOneBitOne,
   output logic externalInterruptFive
);

   localparam logic [3:0] MC_LOAD = 4'(MC_CLKS);

   typedef struct packed {
      smrc_pkg::smrc_state_t state;
      logic stopBit;
      smrc_pkg::smrc_relmode_t relMode;
      logic warmup_clock_select;
      logic [WU_WIDTH-1:0] wuCount;
      logic keyEnable;
      logic keyLevelHigh;
      logic wuSrcLow;
      logic resumeHigh;
      logic [3:0] blindCnt;
      logic wuStart;
      logic cpuRun;
      logic oscStop;
      logic tgClear;
      logic portBit;
      logic intFive;
      logic [7:0] rdata;
   } smrc_core_t;

   smrc_core_t core_reg;
   smrc_core_t core_next;

   logic pinLevel;
   logic pinRise;
   logic pinFall;
   logic keyLevel;
   logic vdLevel;
   logic wuTick;
   logic wuBusy;
   logic wuDone;
   logic pinWake;
   logic keyWake;
   logic vdWake;
   logic haltReq;
   smrc_pkg::smrc_relmode_t wrMode;

   smrc_sync_edge u_pin_sync
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pinIn(releasePin),
      .level(pinLevel),
      .rise(pinRise),
      .fall(pinFall)
   );

   smrc_sync_edge u_key_sync
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pinIn(keyPin),
      .level(keyLevel),
      .rise(),
      .fall()
   );

   smrc_sync_edge u_vd_sync
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pinIn(voltDetect),
      .level(vdLevel),
      .rise(),
      .fall()
   );

   // tick from oscillator latched at entry, high-speed one after a reset wake
   assign wuTick = core_reg.wuSrcLow ? lowOscTick : highOscTick;

   smrc_warmup #(
      .WIDTH(WU_WIDTH)
   ) u_warmup
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(core_reg.wuStart),
      .tick(wuTick),
      .limit(core_reg.wuCount),
      .busy(wuBusy),
      .done(wuDone)
   );

   always_comb
   begin
      haltReq = regWr && (regAddr == `SMRC_ADDR_SYSCTL) && regWdata[`SMRC_BIT_HALT];
      wrMode = regWdata[`SMRC_BIT_RELMODE] ? smrc_pkg::SMRC_REL_LEVEL : smrc_pkg::SMRC_REL_EDGE;
      if (core_reg.relMode == smrc_pkg::SMRC_REL_LEVEL)
         pinWake = pinLevel;
      // edge release on rising edge only
      else
         pinWake = pinRise && (core_reg.blindCnt == 4'h0);
      keyWake = core_reg.keyEnable && (keyLevel == core_reg.keyLevelHigh);
      vdWake = vdLevel && (core_reg.blindCnt == 4'h0);
   end

   always_comb
   begin
      core_next = core_reg;
      core_next.wuStart = 1'b0;
      core_next.tgClear = 1'b0;
      core_next.intFive = 1'b0;
      core_next.rdata = 8'h00;
      // pin as port input and interrupt source
      core_next.portBit = pinLevel;
      core_next.intFive = pinFall;

      // register writes other than the halt request
      if (regWr)
      begin
         case (regAddr)
            `SMRC_ADDR_SYSCTL:
            begin
               core_next.relMode = wrMode;
            end
            `SMRC_ADDR_WUCTL:
               core_next.warmup_clock_select = regWdata[`SMRC_BIT_WARMUP_CLOCK_SELECT];
            `SMRC_ADDR_WUCOUNT:
               core_next.wuCount = regWdata[WU_WIDTH-1:0];
            `SMRC_ADDR_KEYCFG:
            begin
               core_next.keyEnable = regWdata[`SMRC_BIT_KEYEN];
               core_next.keyLevelHigh = regWdata[`SMRC_BIT_KEYLVL];
            end
            default:
            begin
               core_next.rdata = 8'h00;
            end
         endcase
      end

      // one-cycle-late read data, zero elsewhere
      if (regRd)
      begin
         case (regAddr)
            `SMRC_ADDR_SYSCTL:
               core_next.rdata = {core_reg.stopBit, core_reg.relMode == smrc_pkg::SMRC_REL_LEVEL, 6'h00};
            `SMRC_ADDR_WUCTL:
               core_next.rdata = {7'h00, core_reg.warmup_clock_select};
            `SMRC_ADDR_WUCOUNT:
               core_next.rdata = 8'(core_reg.wuCount);
            `SMRC_ADDR_KEYCFG:
               core_next.rdata = {6'h00, core_reg.keyLevelHigh, core_reg.keyEnable};
            `SMRC_ADDR_STATUS:
               core_next.rdata = {core_reg.state, wuBusy, core_reg.resumeHigh, core_reg.wuSrcLow,
                                  keyLevel, vdLevel, pinLevel};
            default:
               core_next.rdata = 8'h00;
         endcase
      end

      if (core_reg.blindCnt != 4'h0)
         core_next.blindCnt = core_reg.blindCnt - 4'h1;

      case (core_reg.state)
         smrc_pkg::SMRC_RUN:
         begin
            // halt bit write starts halt in chosen mode
            if (haltReq)
            begin
               // level mode refuses halt while pin high
               if (wrMode == smrc_pkg::SMRC_REL_LEVEL && pinLevel)
                  core_next.stopBit = 1'b0;
               // edge mode enters regardless of pin
               else
               begin
                  core_next.state = smrc_pkg::SMRC_HALT;
                  core_next.stopBit = 1'b1;
                  core_next.oscStop = 1'b1;
                  core_next.tgClear = 1'b1;
                  core_next.cpuRun = 1'b0;
                  // remember which oscillator fed the core
                  core_next.wuSrcLow = mainOscLow;
                  core_next.resumeHigh = 1'b0;
                  // open one machine cycle blind window
                  core_next.blindCnt = MC_LOAD;
               end
            end
         end
         smrc_pkg::SMRC_HALT:
         begin
            if (resetWake)
            begin
               core_next.state = smrc_pkg::SMRC_WARM;
               core_next.oscStop = 1'b0;
               core_next.wuStart = 1'b1;
               core_next.resumeHigh = 1'b1;
               core_next.wuSrcLow = 1'b0;
               core_next.relMode = smrc_pkg::SMRC_REL_EDGE;
            end
            else if (pinWake || keyWake || vdWake)
            begin
               core_next.state = smrc_pkg::SMRC_WARM;
               core_next.oscStop = 1'b0;
               core_next.wuStart = 1'b1;
            end
         end
         smrc_pkg::SMRC_WARM:
         begin
            // no way back to halt during warm-up
            // core held stopped until count ends
            core_next.cpuRun = 1'b0;
            if (wuDone)
            begin
               core_next.state = smrc_pkg::SMRC_RUN;
               core_next.stopBit = 1'b0;
               core_next.cpuRun = 1'b1;
               core_next.tgClear = 1'b1;
            end
         end
         default:
            core_next.state = smrc_pkg::SMRC_RUN;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         core_reg <= '0;
         core_reg.state <= smrc_pkg::SMRC_RUN;
         core_reg.relMode <= smrc_pkg::SMRC_REL_EDGE;
         core_reg.wuCount <= WU_WIDTH'(`SMRC_WUCOUNT_RST);
         core_reg.cpuRun <= 1'b1;
         core_reg.resumeHigh <= 1'b1;
      end
      else
         core_reg <= core_next;
   end

   assign regRdata = core_reg.rdata;
   assign cpuRun = core_reg.cpuRun;
   assign oscStop = core_reg.oscStop;
   assign tgClear = core_reg.tgClear;
   assign warmupSrcLow = core_reg.wuSrcLow;
   assign highSpeedRunMode = core_reg.resumeHigh;
   assign haltActive = core_reg.stopBit;
   assign portOneBitOne = core_reg.portBit;
   assign externalInterruptFive = core_reg.intFive;

endmodule // smrc_top

// ### sim/smrc_checker.sv
// port assertions of the halt-release controller
// assumes binding into smrc_top with core_clk running in halt
`timescale 1ns/100ps
module smrc_checker
#(
   parameter int MC_CLKS = 4,
   parameter int WU_WIDTH = 8
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic releasePin,
   input wire logic keyPin,
   input wire logic voltDetect,
   input wire logic resetWake,
   input wire logic mainOscLow,
   input wire logic highOscTick,
   input wire logic lowOscTick,
   input wire logic cpuRun,
   input wire logic oscStop,
   input wire logic tgClear,
   input wire logic warmupSrcLow,
   input wire logic highSpeedRunMode,
   input wire logic haltActive,
   input wire logic portOneBitOne,
   input wire logic externalInterruptFive
);
   logic [2:0] ageReg;
   // cycles since reset, so pin history is valid
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         ageReg <= 3'h0;
      else if (ageReg != 3'h7)
         ageReg <= ageReg + 3'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_halt; regWr && regAddr == 3'h0 && regWdata == 8'h80 && cpuRun && !haltActive && !resetWake
      |=> haltActive && oscStop && !cpuRun; endproperty
   a_halt: assert property (p_halt) else $error("no halt entry");
   property p_mode; regWr && regAddr == 3'h0 && regWdata == 8'h40 && cpuRun |=> cpuRun && !haltActive; endproperty
   a_mode: assert property (p_mode) else $error("mode write halted");
   property p_refuse; regWr && regAddr == 3'h0 && regWdata == 8'hc0 && $past(releasePin, 2) && cpuRun
      |=> !haltActive && cpuRun; endproperty
   a_refuse: assert property (p_refuse) else $error("level halt not refused");
   property p_src; $rose(oscStop) |-> warmupSrcLow == $past(mainOscLow) && tgClear; endproperty
   a_src: assert property (p_src) else $error("bad entry capture");
   property p_tg; tgClear |=> !tgClear; endproperty
   a_tg: assert property (p_tg) else $error("timing clear too long");
   property p_warm; $fell(oscStop) |-> !cpuRun [*3]; endproperty
   a_warm: assert property (p_warm) else $error("core ran in warm-up");
   property p_resume; $rose(cpuRun) |-> !haltActive && !oscStop && tgClear; endproperty
   a_resume: assert property (p_resume) else $error("bad resume");
   property p_port; ageReg == 3'h7 |-> portOneBitOne == $past(releasePin, 3); endproperty
   a_port: assert property (p_port) else $error("port level wrong");
   c_halt: cover property ($rose(oscStop));
   c_resume: cover property ($rose(cpuRun));
   c_int: cover property (externalInterruptFive);
endmodule // smrc_checker

bind smrc_top smrc_checker #(.MC_CLKS(MC_CLKS), .WU_WIDTH(WU_WIDTH)) chk (.core_clk, .rst_n, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata, .releasePin, .keyPin, .voltDetect, .resetWake, .mainOscLow,
   .highOscTick, .lowOscTick, .cpuRun, .oscStop, .tgClear, .warmupSrcLow, .highSpeedRunMode, .haltActive,
   .portOneBitOne, .externalInterruptFive);

// ### sim/smrc_pins.sv
// partner model: the wake pin, key input and voltage detector
// assumes callers change levels right after a rising clock edge
`timescale 1ns/100ps
module smrc_pins
(
   output logic releasePin,
   output logic keyPin,
   output logic voltDetect
);
   initial
   begin
      releasePin = 1'b0;
      keyPin = 1'b0;
      voltDetect = 1'b0;
   end
   // level held until software changes it
   task automatic setPin(input logic v);
      releasePin <= v;
   endtask
   task automatic setKey(input logic v);
      keyPin <= v;
   endtask
   task automatic setVolt(input logic v);
      voltDetect <= v;
   endtask
endmodule // smrc_pins

// ### sim/stop_mode_release_control_test.sv
// self-checking bench of the halt-release controller
// assumes smrc_top, smrc_pins and smrc_checker compiled before it
`timescale 1ns/100ps
`include "smrc_consts.svh"
module stop_mode_release_control_test;
   logic core_clk, rst_n, regWr, regRd, resetWake;
   logic mainOscLow, highOscTick, lowOscTick;
   logic [2:0] regAddr, tickCnt;
   logic [7:0] regWdata, regRdata;
   logic releasePin, keyPin, voltDetect, cpuRun, oscStop, tgClear, warmupSrcLow;
   logic highSpeedRunMode, haltActive, portOneBitOne, externalInterruptFive;
   int badCount = 0, nTests = 0;
   smrc_pins pins (.releasePin, .keyPin, .voltDetect);
   smrc_top uut (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .releasePin, .keyPin,
      .voltDetect, .resetWake, .mainOscLow, .highOscTick, .lowOscTick, .cpuRun, .oscStop, .tgClear,
      .warmupSrcLow, .highSpeedRunMode, .haltActive, .portOneBitOne, .externalInterruptFive);
   always #2 core_clk = ~core_clk;
   // oscillator ticks: high every 2 cycles, low every 8
   always @(posedge core_clk)
   begin
      tickCnt <= tickCnt + 3'h1;
      highOscTick <= tickCnt[0];
      lowOscTick <= (tickCnt == 3'h7);
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      nTests++;
      if (g !== e)
      begin
         badCount++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      chk("read data", e, regRdata);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic waitRun(output int n);
      n = 0;
      while (cpuRun !== 1'b1 && n < 500)
      begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_regs;
      #1;
      chk("reset run", 8'h03, {6'h0, cpuRun, highSpeedRunMode});
      rd(3'h0, `SMRC_SYSCTL_RST);
      rd(3'h2, `SMRC_WUCOUNT_RST);
      rd(3'h3, `SMRC_KEYCFG_RST);
      rd(3'h4, 8'h10);
      wr(3'h5, 8'h5a);
      rd(3'h5, 8'h00);
      wr(3'h1, 8'h01);
      rd(3'h1, 8'h01);
      wr(3'h0, 8'h40);
      chk("mode only", 8'h01, {haltActive, cpuRun});
      rd(3'h0, 8'h40);
   endtask
   task automatic t_edge;
      int n;
      wr(3'h2, 8'h09);
      @(posedge core_clk);
      mainOscLow <= 1'b1;
      pins.setPin(1'b1);
      cyc(5);
      wr(3'h0, 8'h80);
      chk("halt pin high", 8'h07, {haltActive, oscStop, warmupSrcLow});
      rd(3'h0, 8'h80);
      @(posedge core_clk);
      pins.setPin(1'b0);
      cyc(8);
      chk("fall ignored", 8'h00, cpuRun);
      @(posedge core_clk);
      pins.setPin(1'b1);
      waitRun(n);
      chk("edge wake", 8'h01, cpuRun);
      @(posedge core_clk);
      pins.setPin(1'b0);
      cyc(4);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= 3'h0;
      regWdata <= 8'h80;
      @(posedge core_clk);
      regWr <= 1'b0;
      pins.setPin(1'b1);
      cyc(30);
      chk("blind edge", 8'h01, oscStop);
      @(posedge core_clk);
      pins.setVolt(1'b1);
      waitRun(n);
      chk("volt wake", 8'h01, cpuRun);
      @(posedge core_clk);
      pins.setVolt(1'b0);
      mainOscLow <= 1'b0;
   endtask
   task automatic t_level;
      int n;
      cyc(4);
      wr(3'h0, 8'hc0);
      chk("refused", 8'h01, {haltActive, cpuRun});
      @(posedge core_clk);
      pins.setPin(1'b0);
      n = 0;
      repeat (6)
      begin
         cyc(1);
         n += int'(externalInterruptFive);
      end
      chk("pulses", 8'h01, n[7:0]);
      // pin seen low on the port bit, after the one interrupt pulse
      chk("pin low", 8'h00, portOneBitOne);
      wr(3'h0, 8'hc0);
      chk("level halt", 8'h06, {haltActive, oscStop, warmupSrcLow});
      @(posedge core_clk);
      pins.setPin(1'b1);
      waitRun(n);
      chk("level wake", 8'h01, cpuRun);
      chk("warm-up span", 8'h01, {7'h0, n >= 24 && n <= 30});
   endtask
   task automatic t_key;
      int n;
      for (int l = 0; l < 2; l++)
      begin
         wr(3'h3, {6'h00, l[0], 1'b1});
         @(posedge core_clk);
         pins.setKey(!l[0]);
         cyc(4);
         wr(3'h0, 8'h80);
         chk("key halt", 8'h01, oscStop);
         @(posedge core_clk);
         pins.setKey(l[0]);
         n = 0;
         while (oscStop === 1'b1 && n < 50)
         begin
            cyc(1);
            n++;
         end
         @(posedge core_clk);
         pins.setKey(!l[0]);
         waitRun(n);
         chk("key wake", 8'h01, {haltActive, oscStop, cpuRun});
      end
      wr(3'h3, 8'h00);
   endtask
   task automatic t_rwake;
      int n;
      @(posedge core_clk);
      mainOscLow <= 1'b1;
      wr(3'h0, 8'h80);
      @(posedge core_clk);
      resetWake <= 1'b1;
      cyc(3);
      @(posedge core_clk);
      resetWake <= 1'b0;
      waitRun(n);
      chk("reset wake", 8'h06, {cpuRun, highSpeedRunMode, warmupSrcLow});
      rd(3'h0, 8'h00);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      resetWake = 1'b0;
      mainOscLow = 1'b0;
      highOscTick = 1'b0;
      lowOscTick = 1'b0;
      regAddr = 3'h0;
      tickCnt = 3'h0;
      regWdata = 8'h00;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs;
      t_edge;
      t_level;
      t_key;
      t_rwake;
      summarize;
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      badCount++;
      summarize;
   end
endmodule // stop_mode_release_control_test
